// ===== common/csiu_map.svh
/*
 Register offsets, field positions, reset values and timing counts of the console
 serial interrupt unit. Assumes a 100 MHz system clock and byte addressing.
*/
`ifndef CSIU_MAP_SVH
`define CSIU_MAP_SVH

`define CSIU_SYS_CLK_NS 10
`define CSIU_CONSOLE_CLK_NS 200
`define CSIU_PRESCALE_DIV 4
`define CSIU_TICK_CYCLES ((`CSIU_CONSOLE_CLK_NS / `CSIU_SYS_CLK_NS) * `CSIU_PRESCALE_DIV)
`define CSIU_REFRESH_NS 12800
`define CSIU_REFRESH_TICKS (`CSIU_REFRESH_NS / (`CSIU_CONSOLE_CLK_NS * `CSIU_PRESCALE_DIV))

`define CSIU_ADR_READY 8'h20
`define CSIU_ADR_CTRL 8'h24
`define CSIU_ADR_SUMMARY 8'h28
`define CSIU_ADR_PRIORITY 8'h2C

`define CSIU_CTRL_RECEIVER_ENABLE_BIT_TERM 0
`define CSIU_CTRL_RECEIVER_ENABLE_BIT_TAPE 1
`define CSIU_CTRL_CLRERR_TERM 2
`define CSIU_CTRL_CLRERR_TAPE 3
`define CSIU_CTRL_RESET 4'h3

`define CSIU_BIT_TERM_TX 0
`define CSIU_BIT_TERM_RX 1
`define CSIU_BIT_TAPE_TX 2
`define CSIU_BIT_TAPE_RX 3

`define CSIU_MODE1_VALUE 8'h4E
`define CSIU_MODE1_CHARLEN_LSB 2
`define CSIU_MODE1_CHARLEN_8 2'h3
`define CSIU_MODE1_DIV16 2'h2
`define CSIU_MODE2_VALUE 8'h00

`define CSIU_CSR_IE_BIT 6
`define CSIU_SEL_MSB 11
`define CSIU_SEL_LSB 8
`define CSIU_SEL_CHAR 4'h0
`define CSIU_SEL_MISC 4'hF
`define CSIU_STAT_READY 0
`define CSIU_STAT_OVERRUN 4
`define CSIU_STAT_STOPERR 5

`endif

// ===== common/csiu_pkg.sv
/*
 Types shared by the console serial interrupt unit. Constants live in csiu_map.svh.
*/
package csiu_pkg;

	typedef enum logic [1:0] {
		CSIU_RPL_IDLE = 2'b01,
		CSIU_RPL_SECOND = 2'b10
	} csiu_reply_e;

	typedef enum logic [1:0] {
		CSIU_PKT_ACK = 2'h0,
		CSIU_PKT_WRITE = 2'h1,
		CSIU_PKT_READ = 2'h2
	} csiu_pkt_e;

	typedef enum logic [2:0] {
		CSIU_REG_TERM_TX_CS = 3'h0,
		CSIU_REG_TERM_RX_CS = 3'h1,
		CSIU_REG_TAPE_TX_CS = 3'h2,
		CSIU_REG_TAPE_RX_CS = 3'h3,
		CSIU_REG_TERM_TX_DB = 3'h4,
		CSIU_REG_TERM_RX_DB = 3'h5,
		CSIU_REG_TAPE_TX_DB = 3'h6,
		CSIU_REG_TAPE_RX_DB = 3'h7
	} csiu_reg_e;

endpackage

// ===== design/csiu_baud_gen.sv
/*
 Baud clock and memory refresh generator. A prescaler models the divide-by-four of
 the console clock; a binary counter then provides the channel clock taps.
 Assumes switch inputs are synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "csiu_map.svh"

module csiu_baud_gen #(
	parameter int TICK_CYCLES = `CSIU_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] term_baud_sel_i,
	input wire logic remote_fast_sel_i,
	input wire logic automatic_production_test_i,
	output logic tape_line_clock_o,
	output logic remote_line_clock_o,
	output logic terminal_line_clock_o,
	output logic refresh_req_o
);
	logic [7:0] presc;
	logic [7:0] ctr;
	wire tick = (presc == 8'(TICK_CYCLES - 1));
	wire refresh_edge = tick && (ctr[3:0] == 4'(`CSIU_REFRESH_TICKS - 1));
	wire next_term = (term_baud_sel_i == 2'h0) ? ctr[2] :
		(term_baud_sel_i == 2'h1) ? ctr[4] :
		(term_baud_sel_i == 2'h2) ? ctr[5] : ctr[7];
	wire next_remote = automatic_production_test_i ? ctr[0] :
		(remote_fast_sel_i ? ctr[5] : ctr[7]);

	// Taps 0, 2, 4, 5 and 7 give 38400, 9600, 2400, 1200 and 300 baud after x16. see R3 see R4
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			presc <= 8'h00;
			ctr <= 8'h00;
			tape_line_clock_o <= 1'b0;
			remote_line_clock_o <= 1'b0;
			terminal_line_clock_o <= 1'b0;
			refresh_req_o <= 1'b0;
		end else begin
			presc <= tick ? 8'h00 : presc + 8'h01;
			ctr <= tick ? ctr + 8'h01 : ctr;
			tape_line_clock_o <= ctr[0]; // see R6
			remote_line_clock_o <= next_remote; // see R6 see R7
			terminal_line_clock_o <= next_term; // see R8
			refresh_req_o <= refresh_edge; // see R5
		end
	end

	a_refresh_period: assert property (@(posedge clk_i) disable iff (rst_i)
		refresh_req_o |=> !refresh_req_o [*8]) else $error("refresh strobe too frequent"); // see R5
endmodule

// ===== design/csiu_core.sv
/*
 Console serial interrupt unit: ready summary, enables, priority and attention
 toward the main processor, console packet handling, and a classic Wishbone slave
 for the ready status and local control. Assumes the serial character engines sit
 outside and that packets arrive at least two cycles apart.
*/
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "csiu_map.svh"

// Contract
// R1 - Each serial channel is set for eight-bit characters, length field binary 11.
// R2 - Channels use one shared external clock for transmit and receive, divided by 16.
// R3 - Baud generator divides the 200 ns console clock by four into a counter.
// R4 - Counter taps give 38400, 9600, 2400, 1200 and 300 baud after x16.
// R5 - The counter also strobes a memory refresh request every 12.8 us.
// R6 - Tape runs at 38400 baud; remote runs at 38400 only during production test.
// R7 - In remote diagnosis a switch picks 300 or 1200 baud for the remote line.
// R8 - Switches pick 9600, 2400, 1200 or 300 baud for the terminal channel.
// R9 - All transmit and receive ready flags read together at I/O address 20.
// R10 - Summary holds four bits set when the matching ready condition is seen.
// R11 - A control/status write with data bit 06 one sets the matching enable.
// R12 - Summary and enable set a pending bit, then attention is raised at level 14.
// R13 - An acknowledge drops attention, replies the priority byte, re-raises if more pend.
// R14 - Processor serves the highest pending first; tape receive highest, terminal transmit lowest.
// R15 - A transmit data write carries the character in the low eight data bits.
// R16 - A taken character goes to its channel and clears its summary and pending bits.
// R17 - Select zero means a character; select F means a miscellaneous command.
// R18 - A receive buffer read replies two bytes: character then captured status.
// R19 - Status flags overrun or stop error for bit 15; parity is masked away.
// R20 - Processor forms done from the ready flag and keeps its own enable copy.
// R21 - Receive errors clear when the receiver is disabled or clear-error is written.
// R22 - Reset clears summary, enable and priority and drops attention.
module csiu_core #(
	parameter int TICK_CYCLES = `CSIU_TICK_CYCLES,
	parameter logic [4:0] ATTN_LEVEL = 5'h14
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic term_tx_ready_flag_i,
	input wire logic term_rx_ready_flag_i,
	input wire logic tape_tx_ready_flag_i,
	input wire logic tape_rx_ready_flag_i,
	input wire logic [7:0] term_rx_char_i,
	input wire logic [7:0] tape_rx_char_i,
	input wire logic [1:0] term_rx_err_i,
	input wire logic [1:0] tape_rx_err_i,
	input wire logic term_parity_err_i,
	input wire logic tape_parity_err_i,
	input wire logic pkt_valid_i,
	input wire logic [1:0] pkt_kind_i,
	input wire logic [2:0] pkt_reg_i,
	input wire logic [15:0] pkt_data_i,
	input wire logic [1:0] term_baud_sel_i,
	input wire logic remote_fast_sel_i,
	input wire logic automatic_production_test_i,
	output logic console_attention_req_o,
	output logic [4:0] interrupt_priority_level_o,
	output logic reply_valid_o,
	output logic reply_last_o,
	output logic [7:0] reply_byte_o,
	output logic term_tx_load_o,
	output logic tape_tx_load_o,
	output logic [7:0] tx_char_o,
	output logic misc_cmd_o,
	output logic [7:0] misc_data_o,
	output logic [1:0] receiver_enable_o,
	output logic [7:0] chan_mode1_o,
	output logic [7:0] chan_mode2_o,
	output logic tape_line_clock_o,
	output logic remote_line_clock_o,
	output logic terminal_line_clock_o,
	output logic refresh_req_o
);
	logic [3:0] summary;
	logic [3:0] enable;
	logic [3:0] pending;
	logic [3:0] ready_q;
	logic raise_q;
	logic [3:0] ctrl;
	logic [1:0] term_err;
	logic [1:0] tape_err;
	logic [7:0] term_rx_buf;
	logic [7:0] tape_rx_buf;
	logic [7:0] second_byte;
	csiu_pkg::csiu_reply_e rstate;

	function automatic logic [7:0] status_byte(input logic ready, input logic [1:0] err);
		status_byte = 8'h00;
		status_byte[`CSIU_STAT_READY] = ready;
		status_byte[`CSIU_STAT_OVERRUN] = err[0];
		status_byte[`CSIU_STAT_STOPERR] = err[1];
	endfunction

	function automatic logic more_than_one(input logic [3:0] v);
		more_than_one = (v & (v - 4'h1)) != 4'h0;
	endfunction

	// Wishbone decode: one register per aligned word, one-cycle ack.
	wire wb_req = cyc_i && stb_i && !ack_o;
	wire wb_wr = wb_req && we_i && sel_i[0];
	wire wr_ctrl = wb_wr && (adr_i == `CSIU_ADR_CTRL);
	wire [3:0] ready_now = {tape_rx_ready_flag_i, tape_tx_ready_flag_i,
		term_rx_ready_flag_i, term_tx_ready_flag_i};
	wire [31:0] rd_data = (adr_i == `CSIU_ADR_READY) ? {28'h0, ready_now} : // see R9
		(adr_i == `CSIU_ADR_CTRL) ? {28'h0, ctrl} :
		(adr_i == `CSIU_ADR_SUMMARY) ? {24'h0, enable, summary} :
		(adr_i == `CSIU_ADR_PRIORITY) ? {28'h0, pending} : 32'h0;

	// Console packet decode.
	wire is_ack = pkt_valid_i && (pkt_kind_i == csiu_pkg::CSIU_PKT_ACK);
	wire is_wr = pkt_valid_i && (pkt_kind_i == csiu_pkg::CSIU_PKT_WRITE);
	wire is_rd = pkt_valid_i && (pkt_kind_i == csiu_pkg::CSIU_PKT_READ);
	wire [3:0] sel_field = pkt_data_i[`CSIU_SEL_MSB:`CSIU_SEL_LSB];
	wire wr_csr = is_wr && !pkt_reg_i[2];
	wire [1:0] csr_chan = pkt_reg_i[1:0];
	wire wr_term_db = is_wr && (pkt_reg_i == csiu_pkg::CSIU_REG_TERM_TX_DB);
	wire wr_tape_db = is_wr && (pkt_reg_i == csiu_pkg::CSIU_REG_TAPE_TX_DB);
	wire term_char = wr_term_db && (sel_field == `CSIU_SEL_CHAR); // see R17
	wire term_misc = wr_term_db && (sel_field == `CSIU_SEL_MISC); // see R17
	wire rd_term_db = is_rd && (pkt_reg_i == csiu_pkg::CSIU_REG_TERM_RX_DB);
	wire rd_tape_db = is_rd && (pkt_reg_i == csiu_pkg::CSIU_REG_TAPE_RX_DB);

	// Bits that a serviced transfer retires from summary and priority.
	wire [3:0] serviced = {rd_tape_db, wr_tape_db, rd_term_db, term_char}; // see R16
	wire [3:0] ready_rise = ready_now & ~ready_q;
	wire [3:0] next_summary = (summary & ~serviced) | ready_rise; // see R10
	// A bit retired in this cycle must not be raised again from its stale summary.
	wire [3:0] newly_pending = summary & ~serviced & enable & ~pending;
	wire [3:0] next_pending = (pending & ~serviced) | newly_pending; // see R12
	wire [3:0] csr_bit = 4'h1 << csr_chan;
	wire [3:0] next_enable = !wr_csr ? enable :
		(pkt_data_i[`CSIU_CSR_IE_BIT] ? (enable | csr_bit) : (enable & ~csr_bit)); // see R11

	// Attention: a fresh request wins over the drop caused by an acknowledge.
	wire next_attn = raise_q ? 1'b1 :
		(is_ack ? more_than_one(pending) : console_attention_req_o); // see R13

	// Clear-error bits are commands; they read back as zero.
	wire [3:0] next_ctrl = wr_ctrl ? dat_i[3:0] : {2'b00, ctrl[1:0]};
	wire term_err_clr = !ctrl[`CSIU_CTRL_RECEIVER_ENABLE_BIT_TERM] || ctrl[`CSIU_CTRL_CLRERR_TERM];
	wire tape_err_clr = !ctrl[`CSIU_CTRL_RECEIVER_ENABLE_BIT_TAPE] || ctrl[`CSIU_CTRL_CLRERR_TAPE];
	// Parity errors are never captured, so they cannot reach the error bit. see R19
	wire [1:0] next_term_err = term_err_clr ? term_rx_err_i : (term_err | term_rx_err_i); // see R21
	wire [1:0] next_tape_err = tape_err_clr ? tape_rx_err_i : (tape_err | tape_rx_err_i); // see R21

	// Reply selection: priority byte, status byte, or character then status.
	wire [7:0] csr_status = status_byte(ready_now[csr_chan],
		csr_chan[0] ? (csr_chan[1] ? tape_err : term_err) : 2'b00); // see R20
	wire two_byte = rd_term_db || rd_tape_db;
	wire one_byte = is_ack || (is_rd && !pkt_reg_i[2]);
	wire [7:0] first_byte = is_ack ? {4'h0, pending} : // see R13
		rd_term_db ? term_rx_buf : rd_tape_db ? tape_rx_buf : csr_status; // see R18
	wire [7:0] next_second = rd_tape_db ? status_byte(ready_now[`CSIU_BIT_TAPE_RX], tape_err) :
		status_byte(ready_now[`CSIU_BIT_TERM_RX], term_err);

	csiu_baud_gen #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_baud (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.term_baud_sel_i(term_baud_sel_i),
		.remote_fast_sel_i(remote_fast_sel_i),
		.automatic_production_test_i(automatic_production_test_i),
		.tape_line_clock_o(tape_line_clock_o),
		.remote_line_clock_o(remote_line_clock_o),
		.terminal_line_clock_o(terminal_line_clock_o),
		.refresh_req_o(refresh_req_o)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
			ctrl <= `CSIU_CTRL_RESET;
		end else begin
			ack_o <= wb_req;
			dat_o <= wb_req ? rd_data : 32'h0;
			ctrl <= next_ctrl;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			summary <= 4'h0; // see R22
			enable <= 4'h0;
			pending <= 4'h0;
			ready_q <= 4'h0;
			raise_q <= 1'b0;
			console_attention_req_o <= 1'b0;
		end else begin
			summary <= next_summary;
			enable <= next_enable;
			pending <= next_pending;
			ready_q <= ready_now;
			raise_q <= |newly_pending; // see R12
			console_attention_req_o <= next_attn;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_err <= 2'b00;
			tape_err <= 2'b00;
			term_rx_buf <= 8'h00;
			tape_rx_buf <= 8'h00;
		end else begin
			term_err <= next_term_err;
			tape_err <= next_tape_err;
			term_rx_buf <= ready_rise[`CSIU_BIT_TERM_RX] ? term_rx_char_i : term_rx_buf;
			tape_rx_buf <= ready_rise[`CSIU_BIT_TAPE_RX] ? tape_rx_char_i : tape_rx_buf;
		end
	end

	// Transmit path: the low eight bits carry the character. see R15 see R16
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_tx_load_o <= 1'b0;
			tape_tx_load_o <= 1'b0;
			tx_char_o <= 8'h00;
			misc_cmd_o <= 1'b0;
			misc_data_o <= 8'h00;
		end else begin
			term_tx_load_o <= term_char;
			tape_tx_load_o <= wr_tape_db;
			tx_char_o <= (term_char || wr_tape_db) ? pkt_data_i[7:0] : tx_char_o;
			misc_cmd_o <= term_misc;
			misc_data_o <= term_misc ? pkt_data_i[7:0] : misc_data_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rstate <= csiu_pkg::CSIU_RPL_IDLE;
			reply_valid_o <= 1'b0;
			reply_last_o <= 1'b0;
			reply_byte_o <= 8'h00;
			second_byte <= 8'h00;
		end else begin
			unique case (rstate)
				csiu_pkg::CSIU_RPL_IDLE: begin
					reply_valid_o <= one_byte || two_byte;
					reply_last_o <= one_byte;
					reply_byte_o <= first_byte;
					second_byte <= next_second;
					rstate <= two_byte ? csiu_pkg::CSIU_RPL_SECOND : csiu_pkg::CSIU_RPL_IDLE;
				end
				csiu_pkg::CSIU_RPL_SECOND: begin
					reply_valid_o <= 1'b1;
					reply_last_o <= 1'b1;
					reply_byte_o <= second_byte; // see R18
					rstate <= csiu_pkg::CSIU_RPL_IDLE;
				end
			endcase
		end
	end

	// Channel mode words are fixed: 8-bit, x16 on the external clock. see R1 see R2
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chan_mode1_o <= `CSIU_MODE1_VALUE;
			chan_mode2_o <= `CSIU_MODE2_VALUE;
			receiver_enable_o <= 2'b00;
			interrupt_priority_level_o <= 5'h00;
		end else begin
			chan_mode1_o <= `CSIU_MODE1_VALUE;
			chan_mode2_o <= `CSIU_MODE2_VALUE;
			receiver_enable_o <= ctrl[1:0];
			interrupt_priority_level_o <= next_attn ? ATTN_LEVEL : 5'h00; // see R12
		end
	end

	sequence s_newly_pending;
		|newly_pending;
	endsequence
	sequence s_attn_up;
		##1 raise_q ##1 console_attention_req_o;
	endsequence

	a_pend_then_attn: assert property (@(posedge clk_i) disable iff (rst_i)
		s_newly_pending |-> s_attn_up) else $error("attention not raised after pending"); // see R12
	a_ack_reply_prio: assert property (@(posedge clk_i) disable iff (rst_i)
		is_ack && rstate == csiu_pkg::CSIU_RPL_IDLE |=> reply_valid_o && reply_last_o
		&& reply_byte_o == {4'h0, $past(pending)}) else $error("ack reply wrong"); // see R13
	a_ack_drops_attn: assert property (@(posedge clk_i) disable iff (rst_i)
		is_ack && !raise_q && !more_than_one(pending) |=> !console_attention_req_o)
		else $error("attention not dropped"); // see R13
	a_two_byte_read: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_term_db && rstate == csiu_pkg::CSIU_RPL_IDLE |=> reply_valid_o && !reply_last_o
		&& reply_byte_o == $past(term_rx_buf) ##1 reply_valid_o && reply_last_o)
		else $error("receive reply not two bytes"); // see R18
	a_ready_sets_sum: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(term_rx_ready_flag_i) |=> summary[`CSIU_BIT_TERM_RX])
		else $error("summary missed a ready rise"); // see R10
	a_tx_clears_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_tape_db && !ready_rise[`CSIU_BIT_TAPE_TX] |=> !summary[`CSIU_BIT_TAPE_TX]
		&& !pending[`CSIU_BIT_TAPE_TX] && tape_tx_load_o) else $error("tx service wrong"); // see R16
	a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_csr && pkt_data_i[`CSIU_CSR_IE_BIT] |=> enable[$past(csr_chan)])
		else $error("enable not set"); // see R11
	a_misc_select: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_term_db |=> misc_cmd_o == ($past(sel_field) == `CSIU_SEL_MISC)
		&& term_tx_load_o == ($past(sel_field) == `CSIU_SEL_CHAR)) else $error("select wrong"); // see R17
	a_err_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl[`CSIU_CTRL_RECEIVER_ENABLE_BIT_TERM] && term_rx_err_i == 2'b00 |=> term_err == 2'b00)
		else $error("error not cleared"); // see R21
	a_reset_clears: assert property (@(posedge clk_i)
		rst_i |=> summary == 4'h0 && pending == 4'h0 && !console_attention_req_o)
		else $error("reset did not clear"); // see R22
endmodule

// ===== sim/csiu_cpu_model.sv
/*
 Processor side of the console packet link: sends acknowledge, write and read
 packets and assembles register words from the reply bytes.
 Assumes the clock of the unit and a reply starting one cycle after each packet.
*/
`timescale 1ns/1ps
module csiu_cpu_model (
	input wire logic clk_i,
	input wire logic reply_valid_i,
	input wire logic [7:0] reply_byte_i,
	output logic pkt_valid_o,
	output logic [1:0] pkt_kind_o,
	output logic [2:0] pkt_reg_o,
	output logic [15:0] pkt_data_o
);
	logic [3:0] en_copy = 4'h0;
	logic [7:0] rq[$];
	initial begin
		pkt_valid_o = 1'b0;
		pkt_kind_o = 2'h0;
		pkt_reg_o = 3'h0;
		pkt_data_o = 16'h0000;
	end
	always @(posedge clk_i) if (reply_valid_i) rq.push_back(reply_byte_i);
	function automatic logic [7:0] pop();
		if (rq.size() == 0) return 8'hXX;
		return rq.pop_front();
	endfunction
	// Three idle cycles keep packets apart and let a two-byte reply land.
	task automatic send(input logic [1:0] k, input logic [2:0] r, input logic [15:0] d);
		rq.delete();
		@(posedge clk_i);
		pkt_valid_o <= 1'b1;
		pkt_kind_o <= k;
		pkt_reg_o <= r;
		pkt_data_o <= d;
		@(posedge clk_i);
		pkt_valid_o <= 1'b0;
		pkt_data_o <= ~d;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic proc_register_write(input logic [2:0] r, input logic [15:0] d);
		if (!r[2]) en_copy[r[1:0]] = d[6];
		send(2'h1, r, d);
	endtask
	task automatic proc_register_read(input logic [2:0] r, output logic [15:0] w);
		logic [7:0] b0;
		logic [7:0] b1;
		send(2'h2, r, 16'h0000);
		b0 = pop();
		b1 = r[2] ? pop() : 8'h00;
		if (r[2]) w = {b1[4] | b1[5], 7'h00, b0};
		else w = {8'h00, b0[0], en_copy[r[1:0]], 6'h00};
	endtask
	task automatic service(output logic [7:0] pend, output int top);
		send(2'h0, 3'h0, 16'h0000);
		pend = pop();
		top = -1;
		for (int i = 0; i < 4; i++) if (pend[i]) top = i;
	endtask
endmodule

// ===== sim/csiu_core_tb.sv
/*
 Self-checking bench of the console serial interrupt unit against a bench model.
 Assumes the packet partner model and a shortened baud tick.
*/
`timescale 1ns/1ps
`include "csiu_map.svh"
module csiu_core_tb;
	localparam int TICK = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0;
	logic [3:0] rdy = 4'h0;
	logic [5:0] errs = 6'h00;
	logic [7:0] term_rx_char_i = 8'h00;
	logic [7:0] tape_rx_char_i = 8'h00;
	logic [1:0] term_baud_sel_i = 2'h0;
	logic remote_fast_sel_i = 1'b0;
	logic automatic_production_test_i = 1'b0;
	logic pkt_valid_i, ack_o, console_attention_req_o, reply_valid_o, reply_last_o, probe;
	logic term_tx_load_o, tape_tx_load_o, misc_cmd_o, refresh_req_o;
	logic tape_line_clock_o, remote_line_clock_o, terminal_line_clock_o;
	logic [1:0] pkt_kind_i, receiver_enable_o;
	logic [2:0] pkt_reg_i;
	logic [15:0] pkt_data_i;
	logic [31:0] dat_o, q;
	logic [31:0] loads = 32'h0;
	logic [31:0] loads_m = 32'h0;
	logic [4:0] interrupt_priority_level_o;
	logic [7:0] reply_byte_o, tx_char_o, misc_data_o, chan_mode1_o, chan_mode2_o, tch, pch, ch;
	logic [3:0] sum_m = 4'h0;
	logic [3:0] en_m = 4'h0;
	logic [3:0] pend_m = 4'h0;
	logic attn_m = 1'b0;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	int which = 0;
	int p;
	int baud_t[9] = '{9600, 2400, 1200, 300, 300, 1200, 38400, 38400, 1};
	int src_t[9] = '{2, 2, 2, 2, 1, 1, 1, 0, 3};
	csiu_core #(.TICK_CYCLES(TICK)) u_csiu_core (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .term_tx_ready_flag_i(rdy[0]),
		.term_rx_ready_flag_i(rdy[1]), .tape_tx_ready_flag_i(rdy[2]),
		.tape_rx_ready_flag_i(rdy[3]), .term_rx_char_i, .tape_rx_char_i,
		.term_rx_err_i(errs[1:0]), .tape_rx_err_i(errs[3:2]), .term_parity_err_i(errs[4]),
		.tape_parity_err_i(errs[5]), .pkt_valid_i, .pkt_kind_i, .pkt_reg_i, .pkt_data_i,
		.term_baud_sel_i, .remote_fast_sel_i, .automatic_production_test_i,
		.console_attention_req_o, .interrupt_priority_level_o, .reply_valid_o, .reply_last_o,
		.reply_byte_o, .term_tx_load_o, .tape_tx_load_o, .tx_char_o, .misc_cmd_o, .misc_data_o,
		.receiver_enable_o, .chan_mode1_o, .chan_mode2_o, .tape_line_clock_o,
		.remote_line_clock_o, .terminal_line_clock_o, .refresh_req_o);
	csiu_cpu_model u_csiu_cpu_model (.clk_i, .reply_valid_i(reply_valid_o),
		.reply_byte_i(reply_byte_o), .pkt_valid_o(pkt_valid_i), .pkt_kind_o(pkt_kind_i),
		.pkt_reg_o(pkt_reg_i), .pkt_data_o(pkt_data_i));
	assign probe = which == 0 ? tape_line_clock_o : which == 1 ? remote_line_clock_o :
		which == 2 ? terminal_line_clock_o : refresh_req_o;
	always #5 clk_i = ~clk_i;
	// Pulses are counted in separate nibbles so one compare covers all three kinds.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		loads <= loads + {23'h0, misc_cmd_o, 3'h0, tape_tx_load_o, 3'h0, term_tx_load_o};
		if (cycles == 40000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel_i <= 4'hF;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(q, e);
	endtask
	task automatic regs();
		rd(`CSIU_ADR_SUMMARY, 32'({en_m, sum_m}));
		rd(`CSIU_ADR_PRIORITY, 32'(pend_m));
		check(32'(console_attention_req_o), 32'(attn_m));
		check(32'(interrupt_priority_level_o), attn_m ? 32'h14 : 32'h0);
	endtask
	// A pending bit is only raised once, so attention is re-raised only by a new one.
	task automatic raise(input logic [3:0] m);
		logic [3:0] n;
		@(posedge clk_i);
		sum_m |= m & ~rdy;
		rdy <= rdy | m;
		repeat (4) @(posedge clk_i);
		n = sum_m & en_m & ~pend_m;
		if (n != 4'h0) attn_m = 1'b1;
		pend_m |= n;
	endtask
	task automatic ack_chk(input int want);
		logic [7:0] pb;
		int top;
		u_csiu_cpu_model.service(pb, top);
		check(32'(pb), 32'(pend_m));
		check(32'(top), 32'(want));
		attn_m = $countones(pend_m) > 1;
		check(32'(console_attention_req_o), 32'(attn_m));
	endtask
	task automatic rx(input logic [2:0] r, input logic [15:0] w);
		logic [15:0] got;
		u_csiu_cpu_model.proc_register_read(r, got);
		check(32'(got), 32'(w));
		if (r[2]) sum_m[r[1:0]] = 1'b0;
		if (r[2]) pend_m[r[1:0]] = 1'b0;
	endtask
	task automatic tx(input logic [2:0] r, input logic [15:0] d, input logic [31:0] inc);
		u_csiu_cpu_model.proc_register_write(r, d);
		loads_m += inc;
		check(loads, loads_m);
		check(32'(inc[8] ? misc_data_o : tx_char_o), 32'(d[7:0]));
		if (inc[0] | inc[4]) sum_m[r[1:0]] = 1'b0;
		if (inc[0] | inc[4]) pend_m[r[1:0]] = 1'b0;
	endtask
	task automatic errp(input logic [5:0] e);
		@(posedge clk_i);
		errs <= e;
		@(posedge clk_i);
		errs <= 6'h00;
	endtask
	task automatic period(input int w);
		realtime t0;
		which = w;
		#1;
		@(posedge probe);
		@(posedge probe);
		t0 = $realtime;
		@(posedge probe);
		p = int'(($realtime - t0) / 10.0);
	endtask
	initial begin
		void'($urandom(45379));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		regs();
		check(32'({chan_mode2_o, chan_mode1_o[3:0]}), 32'hE);
		rd(8'h30, 32'h0);
		u_csiu_cpu_model.proc_register_write(3'h0, 16'h0040);
		u_csiu_cpu_model.proc_register_write(3'h1, 16'h0040);
		u_csiu_cpu_model.proc_register_write(3'h3, 16'h0040);
		u_csiu_cpu_model.proc_register_write(3'h2, 16'hFFBF);
		en_m = 4'hB;
		regs();
		rx(3'h0, 16'h0040);
		tch = 8'($urandom);
		pch = 8'($urandom);
		@(posedge clk_i);
		term_rx_char_i <= tch;
		tape_rx_char_i <= pch;
		raise(4'h2);
		regs();
		ack_chk(1);
		raise(4'h9);
		regs();
		ack_chk(3);
		errp(6'h08);
		rx(3'h7, {1'b1, 7'h00, pch});
		ch = 8'($urandom);
		tx(3'h4, {8'h00, ch}, 32'h1);
		tx(3'h6, {8'h00, ~ch}, 32'h10);
		tx(3'h4, {8'h0F, ch}, 32'h100);
		tx(3'h4, {8'h05, ~ch}, 32'h0);
		rdy <= 4'h2;
		regs();
		ack_chk(1);
		rx(3'h5, {8'h00, tch});
		rdy <= 4'h0;
		regs();
		errp(6'h01);
		rx(3'h5, {1'b1, 7'h00, tch});
		wb(1'b1, `CSIU_ADR_CTRL, 32'h7);
		rx(3'h5, {8'h00, tch});
		rd(`CSIU_ADR_CTRL, 32'h3);
		errp(6'h02);
		wb(1'b1, `CSIU_ADR_CTRL, 32'h2);
		rx(3'h5, {8'h00, tch});
		check(32'(receiver_enable_o), 32'h2);
		wb(1'b1, `CSIU_ADR_CTRL, 32'h3);
		errp(6'h30);
		rx(3'h5, {8'h00, tch});
		for (int i = 0; i < 4; i++) begin
			// Some flags drop first, so that the raise that follows can show fresh rising edges.
			ch = 8'($urandom);
			@(posedge clk_i);
			rdy <= rdy & ch[7:4];
			raise(ch[3:0]);
			rd(`CSIU_ADR_READY, 32'(rdy));
			regs();
		end
		rdy <= 4'h0;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		{sum_m, en_m, pend_m, attn_m} = 13'h0;
		regs();
		for (int s = 0; s < 9; s++) begin
			@(posedge clk_i);
			term_baud_sel_i <= s[1:0];
			remote_fast_sel_i <= s[0];
			automatic_production_test_i <= s > 5;
			period(src_t[s]);
			check(32'(p), 32'(s == 8 ? 12800 / (200 * 4) * TICK : 2 * TICK * 38400 / baud_t[s]));
		end
		close_out();
	end
endmodule
